// file: css_startup_seq.v
// Post-configuration startup sequencer with an AXI4-Lite register slave
//
// Contract
// - Global write enable rises in a chosen phase 1-6, on completion or is kept; default 6.
// - Block memory reads and writes stay blocked until write enable is asserted.
// - With the completion choice, write enable rises once the sensed completion is high.
// - Sensed completion is the pin level, or a one-edge delayed copy with the pipeline option.
// - With the keep choice the write enable holds its present value through startup.
// - Output float is released in a chosen phase 1-6, on completion or kept; default 5.
// - Float release follows sensed completion for the completion choice and holds for keep.
// - The sequencer may stall in a phase 0-6 for all clock manager locks; default no wait.
// - It may stall in a phase 0-6 for impedance match, or automatically; default automatic.
// - The completion pin is activated in a chosen phase 1-6, default 4.
// - With the pipeline option the pin is waited for plus one startup clock edge.
// - The completion pin is open drain by default, or driven high with active drive.
// - With persistence the configuration pins of the chosen mode keep their role.
// - Security is none, level 1 blocking readback, or level 2 blocking reconfiguration too.
// - A 32-bit user revision tag is held, default all ones.
// - The startup clock is chosen among config clock, user clock and test clock.
//
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "css_consts.vh"
module css_startup_seq #(
	parameter NUM_LOCKS = 4,
	parameter [31:0] TAG_DEFAULT = `CSS_TAG_RST
) (
	input wire aclk,
	input wire aresetn,
	input wire clk_en,
	// AXI4-Lite slave
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Startup clock sources, sampled as enables
	input wire config_clock,
	input wire user_clock,
	input wire test_clock,
	// Stall sources
	input wire [NUM_LOCKS-1:0] clock_manager_locked,
	input wire impedance_controller_match,
	input wire impedance_controller_present,
	// Configuration mode: 1 selects the parallel mode
	input wire parallel_config_mode,
	// Completion pin
	input wire complete_pin_in,
	output reg complete_pin_out,
	output reg complete_pin_oe,
	// Global enables to the fabric
	output reg global_write_enable,
	output reg global_output_float,
	output reg block_memory_enable,
	output reg startup_finished,
	output reg readback_allowed,
	output reg reconfig_allowed,
	output reg persist_serial_pins,
	output reg persist_parallel_pins
);

////////////////////////////////////////////////////////////////////////////////
// Registers

reg [31:0] ctrl;
reg [1:0] security;
reg [31:0] user_revision_tag;
reg persist;
reg [1:0] sequencer_clock_select;
reg [2:0] phase;
reg sense_pipe;
reg clk_prev;
reg have_aw;
reg have_w;
reg [7:0] aw_addr;
reg [31:0] w_data;

wire [2:0] write_enable_phase_select = ctrl[`CSS_F_GWE];
wire [2:0] output_release_phase_select = ctrl[`CSS_F_GTS];
wire [2:0] clock_lock_wait_phase = ctrl[`CSS_F_LCK];
wire [2:0] match_wait_phase = ctrl[`CSS_F_MATCH];
wire [2:0] done_phase = ctrl[`CSS_F_DONE];
wire complete_pipeline_option = ctrl[`CSS_B_PIPE];
wire complete_active_drive = ctrl[`CSS_B_DRIVE];
wire match_auto = ctrl[`CSS_B_AUTO];
wire run = ctrl[`CSS_B_START];

////////////////////////////////////////////////////////////////////////////////
// Startup clock selection and edge detect

reg sel_clk;
always @* begin
	case (sequencer_clock_select)
		2'h1: sel_clk = user_clock;
		2'h2: sel_clk = test_clock;
		default: sel_clk = config_clock;
	endcase
end
wire step = sel_clk & ~clk_prev;

// Sensed completion: pin directly or the copy taken on the last startup edge
wire complete_input_sense = complete_pipeline_option ? sense_pipe : complete_pin_in;

// Stall conditions; automatic match waits only where a controller exists
wire locks_ok = &clock_manager_locked;
wire lock_stall = (clock_lock_wait_phase != `CSS_WAIT_NONE) &&
	(phase == clock_lock_wait_phase) && !locks_ok;
wire match_on = match_auto ? impedance_controller_present : (match_wait_phase != `CSS_WAIT_NONE);
wire [2:0] match_at = match_auto ? `CSS_PHASE_LAST : match_wait_phase;
wire match_stall = match_on && (phase == match_at) && !impedance_controller_match;
wire at_end = (phase == `CSS_PHASE_LAST);

// Completion state entered in the last phase once nothing stalls and sensing is high;
// the pipeline option already adds its startup edge through the sensed copy
wire next_finished = at_end && complete_input_sense && !lock_stall && !match_stall;

// Phase hit for a select field: numeric phase or completion
function hit;
	input [2:0] sel;
	input [2:0] ph;
	input done_in;
	begin
		if (sel == `CSS_SEL_DONE)
			hit = done_in;
		else
			hit = (sel != `CSS_SEL_KEEP) && (ph >= sel);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Sequencer

always @(posedge aclk) begin
	if (!aresetn) begin
		phase <= 3'h0;
		sense_pipe <= 1'b0;
		clk_prev <= 1'b0;
		global_write_enable <= 1'b0;
		global_output_float <= 1'b1;
		block_memory_enable <= 1'b0;
		complete_pin_out <= 1'b0;
		complete_pin_oe <= 1'b1;
		startup_finished <= 1'b0;
	end else if (clk_en) begin
		clk_prev <= sel_clk;
		if (step)
			sense_pipe <= complete_pin_in;
		// Counter stops at the last phase; stalls hold it
		if (run && step && !lock_stall && !match_stall && !at_end)
			phase <= phase + 3'h1;
		if (run && hit(write_enable_phase_select, phase, complete_input_sense))
			global_write_enable <= 1'b1;
		block_memory_enable <= global_write_enable;
		if (run && hit(output_release_phase_select, phase, complete_input_sense))
			global_output_float <= 1'b0;
		// Pin low is always driven; high is released unless active drive
		if (run && phase >= done_phase) begin
			complete_pin_out <= 1'b1;
			complete_pin_oe <= complete_active_drive;
		end else begin
			complete_pin_out <= 1'b0;
			complete_pin_oe <= 1'b1;
		end
		if (next_finished)
			startup_finished <= 1'b1;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Security and pin persistence outputs

always @(posedge aclk) begin
	if (!aresetn) begin
		readback_allowed <= 1'b1;
		reconfig_allowed <= 1'b1;
		persist_serial_pins <= 1'b0;
		persist_parallel_pins <= 1'b0;
	end else if (clk_en) begin
		readback_allowed <= (security == `CSS_SEC_NONE);
		reconfig_allowed <= (security != `CSS_SEC_L2);
		persist_serial_pins <= persist && !parallel_config_mode;
		persist_parallel_pins <= persist && parallel_config_mode;
	end
end

////////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave: address and data taken in either order, one write at a time

wire wr_fire = have_aw && have_w && !s_axi_bvalid;
wire wr_map = (aw_addr == `CSS_OFF_CTRL) || (aw_addr == `CSS_OFF_SECURITY) ||
	(aw_addr == `CSS_OFF_TAG) || (aw_addr == `CSS_OFF_PERSIST) ||
	(aw_addr == `CSS_OFF_CLKSEL);

always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_awready <= 1'b1;
		s_axi_wready <= 1'b1;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `CSS_RESP_OKAY;
		have_aw <= 1'b0;
		have_w <= 1'b0;
		aw_addr <= 8'h00;
		w_data <= 32'h00000000;
		ctrl <= `CSS_CTRL_RST;
		security <= `CSS_SEC_NONE;
		user_revision_tag <= TAG_DEFAULT;
		persist <= 1'b0;
		sequencer_clock_select <= `CSS_CLK_CFG;
	end else if (clk_en) begin
		if (s_axi_awvalid && s_axi_awready) begin
			have_aw <= 1'b1;
			aw_addr <= s_axi_awaddr;
			s_axi_awready <= 1'b0;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			have_w <= 1'b1;
			w_data <= s_axi_wdata;
			s_axi_wready <= 1'b0;
		end
		if (wr_fire) begin
			have_aw <= 1'b0;
			have_w <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_map ? `CSS_RESP_OKAY : `CSS_RESP_SLVERR;
			// The control word locks once startup has left phase 0, as the bitstream would
			if (aw_addr == `CSS_OFF_CTRL && s_axi_wstrb == 4'hf && phase == 3'h0)
				ctrl <= w_data;
			if (aw_addr == `CSS_OFF_SECURITY && s_axi_wstrb[0])
				security <= w_data[1:0];
			if (aw_addr == `CSS_OFF_TAG && s_axi_wstrb == 4'hf)
				user_revision_tag <= w_data;
			if (aw_addr == `CSS_OFF_PERSIST && s_axi_wstrb[0])
				persist <= w_data[0];
			if (aw_addr == `CSS_OFF_CLKSEL && s_axi_wstrb[0])
				sequencer_clock_select <= w_data[1:0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
		end
	end
end

// Read path: one cycle from address to data
always @(posedge aclk) begin
	if (!aresetn) begin
		s_axi_arready <= 1'b1;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `CSS_RESP_OKAY;
	end else if (clk_en) begin
		if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `CSS_RESP_OKAY;
			case (s_axi_araddr)
				`CSS_OFF_CTRL: s_axi_rdata <= ctrl;
				`CSS_OFF_PHASE: s_axi_rdata <= {29'h0, phase};
				`CSS_OFF_STATUS: s_axi_rdata <= {26'h0, startup_finished,
					complete_input_sense, block_memory_enable, global_output_float,
					global_write_enable, complete_pin_in};
				`CSS_OFF_SECURITY: s_axi_rdata <= {30'h0, security};
				`CSS_OFF_TAG: s_axi_rdata <= user_revision_tag;
				`CSS_OFF_PERSIST: s_axi_rdata <= {31'h0, persist};
				`CSS_OFF_CLKSEL: s_axi_rdata <= {30'h0, sequencer_clock_select};
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `CSS_RESP_SLVERR;
				end
			endcase
		end
		if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
end

endmodule

// file: css_consts.vh
// Register map, field encodings and reset values of the startup sequencer
`ifndef CSS_CONSTS_VH
`define CSS_CONSTS_VH
`define CSS_OFF_CTRL 8'h00
`define CSS_OFF_PHASE 8'h04
`define CSS_OFF_STATUS 8'h08
`define CSS_OFF_SECURITY 8'h0c
`define CSS_OFF_TAG 8'h10
`define CSS_OFF_PERSIST 8'h14
`define CSS_OFF_CLKSEL 8'h18
// Phase select encodings: 1..6 numeric, 7 complete, 0 keep (write/float)
`define CSS_SEL_KEEP 3'h0
`define CSS_SEL_DONE 3'h7
// Wait phase encodings: 0..6 phase, 7 no wait
`define CSS_WAIT_NONE 3'h7
// Field positions in the control word
`define CSS_F_GWE 2:0
`define CSS_F_GTS 6:4
`define CSS_F_LCK 10:8
`define CSS_F_MATCH 14:12
`define CSS_F_DONE 18:16
`define CSS_B_PIPE 20
`define CSS_B_DRIVE 21
`define CSS_B_AUTO 22
`define CSS_B_START 24
// Reset values, security and response encodings, last phase
`define CSS_CTRL_RST 32'h00447756
`define CSS_TAG_RST 32'hffffffff
`define CSS_SEC_NONE 2'h0
`define CSS_SEC_L1 2'h1
`define CSS_SEC_L2 2'h2
`define CSS_CLK_CFG 2'h0
`define CSS_PHASE_LAST 3'h6
`define CSS_RESP_OKAY 2'h0
`define CSS_RESP_SLVERR 2'h2
`endif

// file: css_chain_model.sv
// Completion pin wire with its pull-up and a daisy-chained peer device
`timescale 1ns/1ps
module css_chain_model (
	input wire pin_out,
	input wire pin_oe,
	input wire peer_busy,
	output wire pin_level
);
	// Pull-up wins unless this device or the still busy peer pulls low
	assign pin_level = !peer_busy && !(pin_oe && !pin_out);
endmodule

// file: css_startup_seq_monitor.sv
// Port assertions for the startup sequencer
`timescale 1ns/1ps
module css_startup_seq_monitor (
	input wire aclk,
	input wire aresetn,
	input wire global_write_enable,
	input wire global_output_float,
	input wire block_memory_enable,
	input wire startup_finished,
	input wire complete_pin_out,
	input wire complete_pin_oe,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire s_axi_rvalid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Read slot taken, then the answer stands with the slot closed
	sequence ar_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_wait;
		s_axi_rvalid && !s_axi_arready;
	endsequence
	block_memory_block_a: assert property (!global_write_enable |-> !block_memory_enable)
		else $error("block memory open early");
	block_memory_follow_a: assert property (global_write_enable |=> block_memory_enable)
		else $error("block memory not opened");
	gwe_hold_a: assert property (global_write_enable |=> global_write_enable)
		else $error("write enable dropped");
	float_hold_a: assert property (!global_output_float |=> !global_output_float)
		else $error("outputs floated again");
	finish_hold_a: assert property (startup_finished |=> startup_finished)
		else $error("finished flag dropped");
	pin_drive_a: assert property (!complete_pin_out |-> complete_pin_oe)
		else $error("pin low not driven");
	pin_hold_a: assert property (complete_pin_out |=> complete_pin_out)
		else $error("completion withdrawn");
	read_answer_a: assert property (ar_take |=> r_wait)
		else $error("read answer late");
	finish_pin_a: assert property (startup_finished |-> complete_pin_out)
		else $error("finished without completion pin");
endmodule
bind css_startup_seq css_startup_seq_monitor u_mon (.aclk, .aresetn, .global_write_enable,
	.global_output_float, .block_memory_enable, .startup_finished, .complete_pin_out,
	.complete_pin_oe, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// file: css_startup_seq_bench.sv
// Self-checking bench for the startup sequencer
`timescale 1ns/1ps
`include "css_consts.vh"
module css_startup_seq_bench;
	reg aclk = 1'h0;
	reg aresetn = 1'h0;
	reg [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	reg [31:0] s_axi_wdata = 32'h0;
	reg [3:0] s_axi_wstrb = 4'h0, clock_manager_locked = 4'hf;
	reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	reg config_clock = 1'h0, parallel_config_mode = 1'h0, peer_busy = 1'h0;
	reg user_clock = 1'h0, test_clock = 1'h0, impedance_controller_match = 1'h0;
	reg impedance_controller_present = 1'h0;
	reg [1:0] pick = 2'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire complete_pin_in, complete_pin_out, complete_pin_oe, global_write_enable;
	wire global_output_float, block_memory_enable, startup_finished, readback_allowed;
	wire reconfig_allowed, persist_serial_pins, persist_parallel_pins;
	integer num_errors = 0, n_checks = 0, seed = 34, cyc = 0, k, p, g, f, d, a;
	css_startup_seq u_css_startup_seq (.aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .config_clock, .user_clock, .test_clock,
		.clock_manager_locked, .impedance_controller_match,
		.impedance_controller_present, .parallel_config_mode, .complete_pin_in,
		.complete_pin_out, .complete_pin_oe, .global_write_enable, .global_output_float,
		.block_memory_enable, .startup_finished, .readback_allowed, .reconfig_allowed,
		.persist_serial_pins, .persist_parallel_pins);
	css_chain_model u_css_chain_model (.pin_out(complete_pin_out), .pin_oe(complete_pin_oe),
		.peer_busy, .pin_level(complete_pin_in));
	initial forever #2 aclk = ~aclk;
	// Hang guard: the whole run needs a few hundred cycles
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			end_of_test;
		end
	end
	task end_of_test;
		begin
			$display("checks %0d errors %0d", n_checks, num_errors);
			if (num_errors == 0 && n_checks > 0)
				$display("All tests passed");
			else
				$display("Some tests failed");
			$finish;
		end
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				num_errors = num_errors + 1;
				$display("unexpected at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task rst;
		begin
			@(posedge aclk);
			aresetn <= 1'h0;
			repeat (2) @(posedge aclk);
			aresetn <= 1'h1;
		end
	endtask
	// Address and data offered together, each dropped when taken
	task wr(input [7:0] ad, input [31:0] v, input [3:0] s, input [1:0] r);
		begin
			@(posedge aclk);
			s_axi_awaddr <= ad;
			s_axi_wdata <= v;
			s_axi_wstrb <= s;
			s_axi_awvalid <= 1'h1;
			s_axi_wvalid <= 1'h1;
			s_axi_bready <= 1'h1;
			do begin
				@(posedge aclk);
				if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'h0;
				if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'h0;
			end while (!s_axi_bvalid);
			s_axi_bready <= 1'h0;
			chk(s_axi_bresp, r);
			@(posedge aclk);
		end
	endtask
	task rd(input [7:0] ad, input [31:0] e, input [1:0] r);
		begin
			@(posedge aclk);
			s_axi_araddr <= ad;
			s_axi_arvalid <= 1'h1;
			s_axi_rready <= 1'h1;
			do begin
				@(posedge aclk);
				if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'h0;
			end while (!s_axi_rvalid);
			s_axi_rready <= 1'h0;
			chk(s_axi_rdata, e);
			chk(s_axi_rresp, r);
		end
	endtask
	// Startup clock pulses are long so every edge is sampled cleanly
	task step(input integer n);
		repeat (n) begin
			@(posedge aclk);
			config_clock <= (pick == 2'h0);
			user_clock <= (pick == 2'h1);
			test_clock <= (pick == 2'h2);
			repeat (3) @(posedge aclk);
			config_clock <= 1'h0;
			user_clock <= 1'h0;
			test_clock <= 1'h0;
			repeat (3) @(posedge aclk);
		end
	endtask
	initial begin
		rst;
		chk(global_write_enable, 32'h0);
		chk(global_output_float, 32'h1);
		rd(`CSS_OFF_CTRL, `CSS_CTRL_RST, `CSS_RESP_OKAY);
		rd(`CSS_OFF_TAG, `CSS_TAG_RST, `CSS_RESP_OKAY);
		rd(`CSS_OFF_SECURITY, 32'h0, `CSS_RESP_OKAY);
		rd(8'h40, 32'h0, `CSS_RESP_SLVERR);
		wr(8'h40, 32'h1, 4'hf, `CSS_RESP_SLVERR);
		wr(`CSS_OFF_CTRL, 32'h0, 4'h1, `CSS_RESP_OKAY);
		rd(`CSS_OFF_CTRL, `CSS_CTRL_RST, `CSS_RESP_OKAY);
		// Random phase choices, checked after every startup edge
		for (k = 0; k < 4; k = k + 1) begin
			rst;
			g = 1 + {$random(seed)} % 6;
			f = 1 + {$random(seed)} % 6;
			d = 1 + {$random(seed)} % 6;
			a = {$random(seed)} % 2;
			wr(`CSS_OFF_CTRL, g | f << 4 | d << 16 | a << 21 | 32'h1007700, 4'hf, 2'h0);
			for (p = 1; p <= 6; p = p + 1) begin
				step(1);
				chk(global_write_enable, p >= g);
				chk(block_memory_enable, p >= g);
				chk(global_output_float, p < f);
				chk(complete_pin_out, p >= d);
				chk(complete_pin_oe, p >= d ? a : 1);
			end
			chk(startup_finished, 32'h1);
		end
		// Completion-driven write enable, kept float, lock stall, slow peer
		rst;
		clock_manager_locked <= 4'h7;
		peer_busy <= 1'h1;
		wr(`CSS_OFF_CTRL, 32'h01127307, 4'hf, 2'h0);
		step(6);
		rd(`CSS_OFF_PHASE, 32'h3, 2'h0);
		@(posedge aclk);
		clock_manager_locked <= 4'hf;
		step(3);
		rd(`CSS_OFF_PHASE, 32'h6, 2'h0);
		chk(complete_pin_oe, 32'h0);
		chk(global_write_enable, 32'h0);
		@(posedge aclk);
		peer_busy <= 1'h0;
		repeat (4) @(posedge aclk);
		chk(global_write_enable, 32'h0);
		step(1);
		chk(global_write_enable, 32'h1);
		chk(global_output_float, 32'h1);
		// User clock steps the sequencer; explicit match stall; control word locked once running
		rst;
		pick <= 2'h1;
		wr(`CSS_OFF_CLKSEL, 32'h1, 4'hf, 2'h0);
		wr(`CSS_OFF_CTRL, 32'h01042756, 4'hf, 2'h0);
		step(4);
		rd(`CSS_OFF_PHASE, 32'h2, 2'h0);
		impedance_controller_match <= 1'h1;
		step(4);
		rd(`CSS_OFF_PHASE, 32'h6, 2'h0);
		chk(startup_finished, 32'h1);
		wr(`CSS_OFF_CTRL, 32'h0, 4'hf, 2'h0);
		rd(`CSS_OFF_CTRL, 32'h01042756, 2'h0);
		// Automatic match wait holds completion while a controller is unmatched
		rst;
		pick <= 2'h0;
		impedance_controller_match <= 1'h0;
		impedance_controller_present <= 1'h1;
		wr(`CSS_OFF_CTRL, `CSS_CTRL_RST | 32'h01000000, 4'hf, 2'h0);
		step(6);
		chk(global_write_enable, 32'h1);
		chk(startup_finished, 32'h0);
		impedance_controller_match <= 1'h1;
		repeat (2) @(posedge aclk);
		chk(startup_finished, 32'h1);
		// Security levels, pin persistence and the revision tag
		parallel_config_mode <= 1'h1;
		wr(`CSS_OFF_SECURITY, 32'h1, 4'hf, 2'h0);
		chk({readback_allowed, reconfig_allowed}, 32'h1);
		wr(`CSS_OFF_SECURITY, 32'h2, 4'hf, 2'h0);
		chk({readback_allowed, reconfig_allowed}, 32'h0);
		wr(`CSS_OFF_PERSIST, 32'h1, 4'hf, 2'h0);
		chk({persist_parallel_pins, persist_serial_pins}, 32'h2);
		g = $random(seed);
		wr(`CSS_OFF_TAG, g, 4'hf, 2'h0);
		rd(`CSS_OFF_TAG, g, 2'h0);
		end_of_test;
	end
endmodule
